//--- include/timer_core_params.svh
// offsets, field positions, reset values and codes of the timer core and its controller
`ifndef TIMER_CORE_PARAMS_SVH
`define TIMER_CORE_PARAMS_SVH

// ----------------------------------------------------------------
// timer register byte addresses on the 16-bit bus
// ----------------------------------------------------------------
`define OFS_COUNT0 5'h00
`define OFS_GEN_BASE 5'h06
`define OFS_GEN_LAST 5'h14
`define OFS_RUN_SYNC 5'h16
`define OFS_CTRL0 5'h18
`define OFS_FLAGS 5'h1e

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define COUNT_RESET 16'h0000
`define GEN_RESET 16'hffff
`define BYTE_RESET 8'h00

// ----------------------------------------------------------------
// fields of channel_control (upper byte) and pin_io_control (lower byte)
// ----------------------------------------------------------------
`define CLR_NONE 3'h0
`define CLR_FIRST 3'h1
`define CLR_SECOND 3'h2
`define CLR_SYNC 3'h3
`define CTRL_BUFFER 3
`define PIO_INIT 0
`define PIO_OUTPUT 1
`define PIO_CAP_FIRST 2
`define PIO_CAP_SECOND 3
`define ACT_LOW 2'h1
`define ACT_HIGH 2'h2
`define ACT_TOGGLE 2'h3
`define RUN_SYNC_MASK 16'h0707

// ----------------------------------------------------------------
// controller software registers
// ----------------------------------------------------------------
`define SW_TARGET 3'h0
`define SW_DATA 3'h1
`define SW_CMD 3'h2
`define SW_RESULT 3'h3
`define SW_STATUS 3'h4
`define SW_MASK 3'h5
`define EV_WRITE_DONE 0
`define EV_READ_DONE 1

`endif

//--- include/timer_core_pkg.sv
// types shared by the timer core and its bus controller
package timer_core_pkg;
   typedef logic [15:0] word_t;
   typedef enum logic [2:0] {
      CTL_IDLE = 3'b001,
      CTL_STROBE = 3'b010,
      CTL_COLLECT = 3'b100
   } ctl_state_e;
endpackage : timer_core_pkg

//--- include/timer_bus_if.sv
// 16-bit register bus between the controller and the timer core
interface timer_bus_if;
   logic [4:0] addr;
   timer_core_pkg::word_t wdata;
   logic [1:0] be;
   logic wr;
   logic rd;
   timer_core_pkg::word_t rdata;
   modport controller (output addr, output wdata, output be, output wr, output rd,
      input rdata);
   modport timer (input addr, input wdata, input be, input wr, input rd, output rdata);
endinterface : timer_bus_if

//--- src/three_channel_timer_core.sv
// three-channel 16-bit timer core: counters, general registers, run and lockstep control
//
// Operation
// R01: three independent 16-bit counters, one per channel
// R02: counters zero on reset and in standby
// R03: master accesses counters only as 16-bit words
// R04: channel 0 counts up; 1,2 may count down
// R05: eight general registers, compare or capture each; the third and fourth never compare or capture, only buffer channel 0
// R06: channel 0 third/fourth buffer first/second
// R07: general registers all ones; word access only
// R08: run register, one run bit per channel
// R09: stopping keeps the compare pin level
// R10: pin control write while stopped drives initial level
// R11: upper five bits read zero, written zero
// R12: lockstep register, one bit per channel
// R13: software sets lockstep on two or more channels
// R14: lockstep clear needs lockstep bit and clear source
// R15: byte registers take byte and word access
// R16: write to lockstep counter presets all lockstep counters
// R17: wrap from all ones sets flag, keeps counting
// R18: stopped counter holds, stays writable, resumes
// R19: bus write beats count tick same cycle
`include "timer_core_params.svh"

module three_channel_timer_core (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // register bus
   timer_bus_if.timer bus,
   // counting and capture events
   input wire logic standby_in,
   input wire logic [2:0] count_tick_in,
   input wire logic [2:0] count_down_in,
   input wire logic [2:0] capture_in,
   // compare/capture pins and status
   output logic [2:0] compare_capture_pin_out,
   output logic [2:0] compare_capture_pin_oe_out,
   output logic [2:0] wrap_up_flag_out
);

   timer_core_pkg::word_t count_q [3];
   timer_core_pkg::word_t gen_q [8];
   timer_core_pkg::word_t gen_d [8];
   timer_core_pkg::word_t rdata_q;
   logic [7:0] ctrl_q [3];
   logic [7:0] pio_q [3];
   logic [2:0] run_q;
   logic [2:0] sync_q;
   logic [2:0] flag_q;
   logic [2:0] pin_q;
   logic [2:0] oe_q;
   logic wr_word;
   logic preset_sync;
   logic sync_clr_src;
   logic [4:0] gen_off;
   logic [2:0] cnt_wr;
   logic [2:0] step;
   logic [2:0] match_a;
   logic [2:0] match_b;
   logic [2:0] ev_a;
   logic [2:0] ev_b;
   logic [2:0] own_clr;
   logic [2:0] clr;
   logic [2:0] wrap;
   logic [2:0] pio_wr;
   logic [2:0] ctrl_wr;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // byte-lane writes to word registers are dropped, not merged
   assign wr_word = bus.wr & (bus.be == 2'b11); // R03 R07
   assign preset_sync = |(cnt_wr & sync_q); // R16
   assign sync_clr_src = |(own_clr & sync_q);
   assign gen_off = bus.addr - `OFS_GEN_BASE;

   // ----------------------------------------------------------------
   // per-channel counter, control and pin
   // ----------------------------------------------------------------
   generate
      for (genvar c = 0; c < 3; c++) begin : g_chan
         localparam int FA = (c == 0) ? 0 : 2 * c + 2;
         localparam bit DOWN_OK = (c != 0);
         logic down;
         logic [1:0] act;

         assign down = DOWN_OK & count_down_in[c]; // R04
         assign cnt_wr[c] = wr_word & (bus.addr == `OFS_COUNT0 + 5'(2 * c)); // R03
         assign pio_wr[c] = bus.wr & bus.be[0] & (bus.addr == `OFS_CTRL0 + 5'(2 * c)); // R15
         assign ctrl_wr[c] = bus.wr & bus.be[1] & (bus.addr == `OFS_CTRL0 + 5'(2 * c)); // R15
         assign step[c] = run_q[c] & count_tick_in[c]; // R08 R18
         assign match_a[c] = step[c] & (count_q[c] == gen_q[FA]);
         assign match_b[c] = step[c] & (count_q[c] == gen_q[FA + 1]);
         assign ev_a[c] = pio_q[c][`PIO_CAP_FIRST] ? capture_in[c] : match_a[c]; // R05
         assign ev_b[c] = pio_q[c][`PIO_CAP_SECOND] ? capture_in[c] : match_b[c]; // R05
         assign own_clr[c] = ((ctrl_q[c][2:0] == `CLR_FIRST) & ev_a[c])
            | ((ctrl_q[c][2:0] == `CLR_SECOND) & ev_b[c]);
         assign clr[c] = own_clr[c]
            | (sync_q[c] & (ctrl_q[c][2:0] == `CLR_SYNC) & sync_clr_src); // R14
         assign wrap[c] = step[c] & ~down & (count_q[c] == 16'hffff); // R17
         assign act = (match_a[c] & ~pio_q[c][`PIO_CAP_FIRST]) ? pio_q[c][5:4] : pio_q[c][7:6];

         always_ff @(posedge ref_clk_in or posedge rst_in) begin
            if (rst_in) begin
               count_q[c] <= `COUNT_RESET; // R02
            end else if (standby_in) begin
               count_q[c] <= `COUNT_RESET; // R02
            end else if (cnt_wr[c] | (sync_q[c] & preset_sync)) begin
               count_q[c] <= bus.wdata; // R16 R18 R19
            end else if (clr[c]) begin
               count_q[c] <= `COUNT_RESET;
            end else if (step[c]) begin
               count_q[c] <= down ? count_q[c] - 16'h0001 : count_q[c] + 16'h0001; // R01 R04 R17
            end
         end

         always_ff @(posedge ref_clk_in or posedge rst_in) begin
            if (rst_in) begin
               ctrl_q[c] <= `BYTE_RESET;
               pio_q[c] <= `BYTE_RESET;
            end else if (standby_in) begin
               ctrl_q[c] <= `BYTE_RESET;
               pio_q[c] <= `BYTE_RESET;
            end else begin
               if (ctrl_wr[c]) begin
                  ctrl_q[c] <= bus.wdata[15:8];
               end
               if (pio_wr[c]) begin
                  pio_q[c] <= bus.wdata[7:0];
               end
            end
         end

         // a stopped channel never matches, so the pin simply keeps its level
         always_ff @(posedge ref_clk_in or posedge rst_in) begin
            if (rst_in) begin
               pin_q[c] <= 1'b0;
               oe_q[c] <= 1'b0;
            end else if (standby_in) begin
               pin_q[c] <= 1'b0;
               oe_q[c] <= 1'b0;
            end else if (pio_wr[c]) begin
               oe_q[c] <= bus.wdata[`PIO_OUTPUT];
               if (!run_q[c]) begin
                  pin_q[c] <= bus.wdata[`PIO_INIT]; // R10
               end
            end else if (oe_q[c] & ((match_a[c] & ~pio_q[c][`PIO_CAP_FIRST])
                  | (match_b[c] & ~pio_q[c][`PIO_CAP_SECOND]))) begin
               unique case (act)
                  `ACT_LOW: pin_q[c] <= 1'b0;
                  `ACT_HIGH: pin_q[c] <= 1'b1;
                  `ACT_TOGGLE: pin_q[c] <= ~pin_q[c];
                  default: pin_q[c] <= pin_q[c]; // R09
               endcase
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // general registers
   // ----------------------------------------------------------------
   always_comb begin
      int fa;
      fa = 0;
      for (int i = 0; i < 8; i++) begin
         gen_d[i] = gen_q[i];
      end
      for (int c = 0; c < 3; c++) begin
         fa = (c == 0) ? 0 : 2 * c + 2;
         if (ev_a[c] & pio_q[c][`PIO_CAP_FIRST]) begin
            gen_d[fa] = count_q[c]; // R05
         end
         if (ev_b[c] & pio_q[c][`PIO_CAP_SECOND]) begin
            gen_d[fa + 1] = count_q[c]; // R05
         end
      end
      // capture pushes the old value into the buffer; compare pulls the buffer in
      if (ctrl_q[0][`CTRL_BUFFER]) begin
         if (pio_q[0][`PIO_CAP_FIRST]) begin
            if (ev_a[0]) begin
               gen_d[2] = gen_q[0]; // R06
            end
         end else if (match_a[0]) begin
            gen_d[0] = gen_q[2]; // R06
         end
         if (pio_q[0][`PIO_CAP_SECOND]) begin
            if (ev_b[0]) begin
               gen_d[3] = gen_q[1]; // R06
            end
         end else if (match_b[0]) begin
            gen_d[1] = gen_q[3]; // R06
         end
      end
      if (wr_word && bus.addr >= `OFS_GEN_BASE && bus.addr <= `OFS_GEN_LAST) begin
         gen_d[gen_off[3:1]] = bus.wdata; // R07
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < 8; i++) begin
            gen_q[i] <= `GEN_RESET; // R07
         end
      end else begin
         for (int i = 0; i < 8; i++) begin
            gen_q[i] <= standby_in ? `GEN_RESET : gen_d[i]; // R07
         end
      end
   end

   // ----------------------------------------------------------------
   // run, lockstep and wrap flags
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         run_q <= 3'h0; // R08
         sync_q <= 3'h0; // R12
      end else if (standby_in) begin
         run_q <= 3'h0;
         sync_q <= 3'h0;
      end else if (bus.wr && bus.addr == `OFS_RUN_SYNC) begin
         if (bus.be[1]) begin
            run_q <= bus.wdata[10:8]; // R08 R15
         end
         if (bus.be[0]) begin
            sync_q <= bus.wdata[2:0]; // R12 R15
         end
      end
   end

   // a new wrap in the clearing cycle keeps the flag set
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         flag_q <= 3'h0;
      end else if (standby_in) begin
         flag_q <= 3'h0;
      end else if (bus.wr && bus.be[0] && bus.addr == `OFS_FLAGS) begin
         flag_q <= (flag_q & bus.wdata[2:0]) | wrap; // R17
      end else begin
         flag_q <= flag_q | wrap; // R17
      end
   end

   // ----------------------------------------------------------------
   // read data, one cycle after the strobe
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_q <= 16'h0000;
      end else if (bus.rd) begin
         if (bus.addr >= `OFS_GEN_BASE && bus.addr <= `OFS_GEN_LAST) begin
            rdata_q <= gen_q[gen_off[3:1]];
         end else begin
            unique case (bus.addr)
               5'h00: rdata_q <= count_q[0];
               5'h02: rdata_q <= count_q[1];
               5'h04: rdata_q <= count_q[2];
               `OFS_RUN_SYNC: rdata_q <= {5'h00, run_q, 5'h00, sync_q}; // R11
               5'h18: rdata_q <= {ctrl_q[0], pio_q[0]};
               5'h1a: rdata_q <= {ctrl_q[1], pio_q[1]};
               5'h1c: rdata_q <= {ctrl_q[2], pio_q[2]};
               `OFS_FLAGS: rdata_q <= {13'h0000, flag_q};
               default: rdata_q <= 16'h0000;
            endcase
         end
      end
   end

   assign bus.rdata = rdata_q;
   assign compare_capture_pin_out = pin_q;
   assign compare_capture_pin_oe_out = oe_q;
   assign wrap_up_flag_out = flag_q;

endmodule : three_channel_timer_core

//--- src/timer_bus_controller.sv
// bus master that runs single timer register accesses on software command
`include "timer_core_params.svh"

module timer_bus_controller (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // software port
   input wire logic [2:0] sw_addr_in,
   input wire logic [15:0] sw_wdata_in,
   input wire logic sw_wr_in,
   input wire logic sw_rd_in,
   output logic [15:0] sw_rdata_out,
   output logic irq_out,
   // timer bus
   timer_bus_if.controller bus
);

   timer_core_pkg::ctl_state_e state_q;
   logic [4:0] taddr_q;
   logic [1:0] tbe_q;
   timer_core_pkg::word_t tdata_q;
   timer_core_pkg::word_t result_q;
   timer_core_pkg::word_t sw_rdata_q;
   logic [4:0] baddr_q;
   logic [1:0] bbe_q;
   timer_core_pkg::word_t bwdata_q;
   logic bwr_q;
   logic brd_q;
   logic is_read_q;
   logic [1:0] status_q;
   logic [1:0] mask_q;
   logic irq_q;
   logic [1:0] done;
   logic go;

   assign go = sw_wr_in && sw_addr_in == `SW_CMD && state_q == timer_core_pkg::CTL_IDLE;

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         taddr_q <= 5'h00;
         tbe_q <= 2'h3;
         tdata_q <= 16'h0000;
         mask_q <= 2'h0;
      end else if (sw_wr_in) begin
         if (sw_addr_in == `SW_TARGET) begin
            taddr_q <= {sw_wdata_in[4:1], 1'b0};
            tbe_q <= sw_wdata_in[9:8];
         end
         if (sw_addr_in == `SW_DATA) begin
            tdata_q <= sw_wdata_in;
         end
         if (sw_addr_in == `SW_MASK) begin
            mask_q <= sw_wdata_in[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // one access: strobe cycle, then collect cycle for reads
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= timer_core_pkg::CTL_IDLE;
         baddr_q <= 5'h00;
         bbe_q <= 2'h0;
         bwdata_q <= 16'h0000;
         bwr_q <= 1'b0;
         brd_q <= 1'b0;
         is_read_q <= 1'b0;
         result_q <= 16'h0000;
      end else begin
         bwr_q <= 1'b0;
         brd_q <= 1'b0;
         unique case (state_q)
            timer_core_pkg::CTL_IDLE: begin
               if (go && (sw_wdata_in[0] | sw_wdata_in[1])) begin
                  baddr_q <= taddr_q;
                  // word registers never see a byte lane access
                  bbe_q <= (taddr_q < `OFS_RUN_SYNC) ? 2'h3 : tbe_q; // R03 R07 R15
                  // reserved run and lockstep bits always go out as zero
                  bwdata_q <= (taddr_q == `OFS_RUN_SYNC) ?
                     (tdata_q & `RUN_SYNC_MASK) : tdata_q; // R11
                  bwr_q <= sw_wdata_in[0];
                  brd_q <= ~sw_wdata_in[0];
                  is_read_q <= ~sw_wdata_in[0];
                  state_q <= timer_core_pkg::CTL_STROBE;
               end
            end
            timer_core_pkg::CTL_STROBE: begin
               state_q <= is_read_q ? timer_core_pkg::CTL_COLLECT : timer_core_pkg::CTL_IDLE;
            end
            timer_core_pkg::CTL_COLLECT: begin
               result_q <= bus.rdata;
               state_q <= timer_core_pkg::CTL_IDLE;
            end
         endcase
      end
   end

   assign done[`EV_WRITE_DONE] = state_q == timer_core_pkg::CTL_STROBE && !is_read_q;
   assign done[`EV_READ_DONE] = state_q == timer_core_pkg::CTL_COLLECT;

   // ----------------------------------------------------------------
   // status, interrupt and read-back
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         status_q <= 2'h0;
         irq_q <= 1'b0;
      end else begin
         // an event in the clearing cycle stays set
         if (sw_wr_in && sw_addr_in == `SW_STATUS) begin
            status_q <= (status_q & ~sw_wdata_in[1:0]) | done;
            irq_q <= |(((status_q & ~sw_wdata_in[1:0]) | done) & mask_q);
         end else begin
            status_q <= status_q | done;
            irq_q <= |((status_q | done) & mask_q);
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sw_rdata_q <= 16'h0000;
      end else if (sw_rd_in) begin
         unique case (sw_addr_in)
            `SW_TARGET: sw_rdata_q <= {6'h00, tbe_q, 3'h0, taddr_q};
            `SW_DATA: sw_rdata_q <= tdata_q;
            `SW_RESULT: sw_rdata_q <= result_q;
            `SW_STATUS: sw_rdata_q <= {13'h0000, state_q != timer_core_pkg::CTL_IDLE, status_q};
            `SW_MASK: sw_rdata_q <= {14'h0000, mask_q};
            default: sw_rdata_q <= 16'h0000;
         endcase
      end
   end

   assign bus.addr = baddr_q;
   assign bus.be = bbe_q;
   assign bus.wdata = bwdata_q;
   assign bus.wr = bwr_q;
   assign bus.rd = brd_q;
   assign sw_rdata_out = sw_rdata_q;
   assign irq_out = irq_q;

endmodule : timer_bus_controller

//--- verification/timer_bus_asserts.sv
// checker for the bus joining the controller and the timer core
`include "timer_core_params.svh"

module timer_bus_asserts (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // bus signals
   input wire logic [4:0] addr,
   input wire timer_core_pkg::word_t wdata,
   input wire logic [1:0] be,
   input wire logic wr,
   input wire logic rd,
   input wire timer_core_pkg::word_t rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   a_no_overlap: assert property (!(wr && rd))
      else $error("bus read and write in one cycle");
   a_wr_pulse: assert property (wr |=> !wr)
      else $error("write strobe longer than one cycle");
   a_rd_pulse: assert property (rd |=> !rd)
      else $error("read strobe longer than one cycle");
   a_count_word:
      assert property ((wr || rd) && addr < `OFS_GEN_BASE |-> be == 2'b11)
      else $error("counter access not a full word");
   a_gen_word:
      assert property ((wr || rd) && addr >= `OFS_GEN_BASE && addr <= `OFS_GEN_LAST
         |-> be == 2'b11)
      else $error("general register access not a full word");
   a_addr_even: assert property ((wr || rd) |-> !addr[0])
      else $error("odd bus address");
   a_run_wmask:
      assert property (wr && addr == `OFS_RUN_SYNC |-> (wdata & ~`RUN_SYNC_MASK) == 16'h0000)
      else $error("reserved run bits written as one");
   a_run_rzero:
      assert property (rd && addr == `OFS_RUN_SYNC |=> (rdata & ~`RUN_SYNC_MASK) == 16'h0000)
      else $error("reserved run bits read as one");

   c_write: cover property (wr && addr == `OFS_COUNT0);
   c_read: cover property (rd && addr == `OFS_RUN_SYNC);
   c_gen: cover property (wr && addr == `OFS_GEN_BASE);
endmodule : timer_bus_asserts

//--- verification/testbench.sv
// self-checking bench joining the bus controller and the timer core
`include "timer_core_params.svh"
`define CHECK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------
   // signals
   // ---------------------------------------------
   logic ref_clk_in, rst_in, standby_in, sw_wr_in, sw_rd_in, irq_out;
   logic [2:0] count_tick_in, count_down_in, capture_in, sw_addr_in;
   logic [2:0] pin_level, pin_drive, wrap_flags;
   logic [15:0] sw_wdata_in, sw_rdata_out;
   int miscompares = 0;
   int total_checks = 0;

   timer_bus_if u_timer_bus_if ();
   timer_bus_controller u_timer_bus_controller (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .sw_addr_in(sw_addr_in), .sw_wdata_in(sw_wdata_in), .sw_wr_in(sw_wr_in),
      .sw_rd_in(sw_rd_in), .sw_rdata_out(sw_rdata_out), .irq_out(irq_out),
      .bus(u_timer_bus_if.controller));
   three_channel_timer_core u_three_channel_timer_core (.ref_clk_in(ref_clk_in),
      .rst_in(rst_in), .bus(u_timer_bus_if.timer), .standby_in(standby_in),
      .count_tick_in(count_tick_in), .count_down_in(count_down_in),
      .capture_in(capture_in), .compare_capture_pin_out(pin_level),
      .compare_capture_pin_oe_out(pin_drive), .wrap_up_flag_out(wrap_flags));
   timer_bus_asserts u_timer_bus_asserts (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .addr(u_timer_bus_if.addr), .wdata(u_timer_bus_if.wdata), .be(u_timer_bus_if.be),
      .wr(u_timer_bus_if.wr), .rd(u_timer_bus_if.rd), .rdata(u_timer_bus_if.rdata));

   // ---------------------------------------------
   // bus tasks
   // ---------------------------------------------
   task automatic sw_write(input logic [2:0] a, input logic [15:0] d);
      @(posedge ref_clk_in);
      sw_addr_in <= a;
      sw_wdata_in <= d;
      sw_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      sw_wr_in <= 1'b0;
   endtask : sw_write

   task automatic sw_read(input logic [2:0] a, output logic [15:0] d);
      @(posedge ref_clk_in);
      sw_addr_in <= a;
      sw_rd_in <= 1'b1;
      @(posedge ref_clk_in);
      sw_rd_in <= 1'b0;
      #1;
      d = sw_rdata_out;
   endtask : sw_read

   task automatic issue(input logic [15:0] cmd, input logic [4:0] a, input logic [15:0] d);
      sw_write(`SW_TARGET, {6'h00, 2'b11, 3'h0, a[4:1], 1'b0});
      sw_write(`SW_DATA, d);
      sw_write(`SW_CMD, cmd);
   endtask : issue

   // polls the done bit with a bound, so a stuck controller cannot hang the run
   task automatic xfer(input logic [15:0] cmd, input logic [4:0] a, input logic [15:0] d,
      output logic [15:0] q);
      logic [15:0] s = 16'h0000;
      int n = 0;
      issue(cmd, a, d);
      while (s[cmd[1]] !== 1'b1 && n < 20) begin
         sw_read(`SW_STATUS, s);
         n++;
      end
      `CHECK("command done", 1'b1, s[cmd[1]])
      sw_write(`SW_STATUS, 16'h0003);
      sw_read(`SW_RESULT, q);
   endtask : xfer

   task automatic wr16(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] q;
      xfer(16'h0001, a, d, q);
   endtask : wr16

   task automatic chk(input logic [4:0] a, input logic [15:0] e);
      logic [15:0] q;
      xfer(16'h0002, a, 16'h0000, q);
      `CHECK($sformatf("reg %h", a), e, q)
   endtask : chk

   task automatic tick(input logic [2:0] m, input int n);
      @(posedge ref_clk_in);
      count_tick_in <= m;
      repeat (n) @(posedge ref_clk_in);
      count_tick_in <= 3'b000;
   endtask : tick

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic test_reset();
      for (int i = 0; i < 3; i++) chk(5'(2 * i), `COUNT_RESET);
      for (int i = 0; i < 8; i++) chk(5'(`OFS_GEN_BASE + 2 * i), `GEN_RESET);
      chk(`OFS_RUN_SYNC, 16'h0000);
   endtask : test_reset

   task automatic test_pin_run();
      wr16(`OFS_CTRL0, 16'h0033);
      @(negedge ref_clk_in);
      `CHECK("pin level", 1'b1, pin_level[0])
      `CHECK("pin drive", 1'b1, pin_drive[0])
      wr16(`OFS_GEN_BASE, 16'h0002);
      wr16(`OFS_RUN_SYNC, 16'h0100);
      tick(3'b001, 3);
      @(negedge ref_clk_in);
      `CHECK("pin after match", 1'b0, pin_level[0])
      wr16(`OFS_RUN_SYNC, 16'h0000);
      tick(3'b001, 2);
      @(negedge ref_clk_in);
      `CHECK("pin after stop", 1'b0, pin_level[0])
      chk(`OFS_COUNT0, 16'h0003);
      wr16(`OFS_RUN_SYNC, 16'h0100);
      tick(3'b001, 1);
      wr16(`OFS_RUN_SYNC, 16'h0000);
      chk(`OFS_COUNT0, 16'h0004);
   endtask : test_pin_run

   task automatic test_direction();
      wr16(`OFS_COUNT0, 16'h0000);
      wr16(5'h02, 16'h000a);
      @(posedge ref_clk_in);
      count_down_in <= 3'b011;
      wr16(`OFS_RUN_SYNC, 16'h0300);
      tick(3'b011, 3);
      wr16(`OFS_RUN_SYNC, 16'h0000);
      count_down_in <= 3'b000;
      chk(`OFS_COUNT0, 16'h0003);
      chk(5'h02, 16'h0007);
   endtask : test_direction

   task automatic test_wrap();
      wr16(5'h04, 16'hffff);
      wr16(`OFS_RUN_SYNC, 16'h0400);
      tick(3'b100, 1);
      @(negedge ref_clk_in);
      `CHECK("wrap flag", 3'b100, wrap_flags)
      wr16(`OFS_RUN_SYNC, 16'h0000);
      chk(5'h04, 16'h0000);
      wr16(`OFS_FLAGS, 16'h0000);
      @(negedge ref_clk_in);
      `CHECK("wrap cleared", 3'b000, wrap_flags)
   endtask : test_wrap

   task automatic test_lockstep();
      wr16(`OFS_RUN_SYNC, 16'hffff);
      chk(`OFS_RUN_SYNC, 16'h0707);
      wr16(`OFS_RUN_SYNC, 16'h0003);
      wr16(5'h04, 16'h0055);
      wr16(`OFS_COUNT0, 16'h1234);
      chk(5'h02, 16'h1234);
      chk(5'h04, 16'h0055);
      wr16(`OFS_RUN_SYNC, 16'h0000);
   endtask : test_lockstep

   task automatic test_standby();
      wr16(`OFS_COUNT0, 16'h00aa);
      @(posedge ref_clk_in);
      standby_in <= 1'b1;
      @(posedge ref_clk_in);
      standby_in <= 1'b0;
      chk(`OFS_COUNT0, `COUNT_RESET);
      chk(`OFS_GEN_BASE, `GEN_RESET);
   endtask : test_standby

   task automatic test_irq();
      logic [15:0] s;
      sw_write(`SW_MASK, 16'h0001);
      issue(16'h0001, `OFS_GEN_BASE, 16'h0100);
      repeat (4) @(negedge ref_clk_in);
      `CHECK("irq set", 1'b1, irq_out)
      sw_write(`SW_STATUS, 16'h0001);
      repeat (2) @(negedge ref_clk_in);
      `CHECK("irq cleared", 1'b0, irq_out)
      sw_write(`SW_MASK, 16'h0000);
      issue(16'h0001, `OFS_GEN_BASE, 16'h0200);
      repeat (4) @(negedge ref_clk_in);
      `CHECK("irq masked", 1'b0, irq_out)
      sw_read(`SW_STATUS, s);
      `CHECK("status sticky", 1'b1, s[0])
      sw_write(`SW_STATUS, 16'h0001);
   endtask : test_irq

   // expects the first general register left at 0200 by test_irq
   task automatic test_capture();
      wr16(`OFS_RUN_SYNC, 16'h0003);
      wr16(`OFS_COUNT0, 16'h0040);
      wr16(`OFS_CTRL0, 16'h0904);
      wr16(5'h1a, 16'h0300);
      @(posedge ref_clk_in);
      capture_in <= 3'b001;
      @(posedge ref_clk_in);
      capture_in <= 3'b000;
      chk(`OFS_GEN_BASE, 16'h0040);
      chk(5'h0a, 16'h0200);
      chk(5'h02, 16'h0000);
   endtask : test_capture

   task automatic stop_test();
      if (miscompares == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test

   // ---------------------------------------------
   // run
   // ---------------------------------------------
   initial begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end

   initial begin
      rst_in = 1'b1;
      standby_in = 1'b0;
      count_tick_in = 3'b000;
      count_down_in = 3'b000;
      capture_in = 3'b000;
      sw_addr_in = 3'h0;
      sw_wdata_in = 16'h0000;
      sw_wr_in = 1'b0;
      sw_rd_in = 1'b0;
      repeat (3) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      test_reset();
      test_pin_run();
      test_direction();
      test_wrap();
      test_lockstep();
      test_standby();
      test_irq();
      test_capture();
      stop_test();
   end

   // the whole run needs well under a thousand cycles; this bound is far above that
   initial begin
      #(40 * 20000);
      miscompares++;
      stop_test();
   end
endmodule : testbench
